/* File: inc/tap_consts.svh */
// Register offsets, field positions and reset values of the tap registers
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH
`define TAP_CONFIG_ADDR 8'h21
`define TAP_STATUS_ADDR 8'h22
`define TAP_CONFIG_RESET 8'h00
`define TAP_STATUS_RESET 8'h00
`define CFG_DP_ABORT 7
`define CFG_LATCH_EN 6
`define CFG_Z_DOUBLE 5
`define CFG_Z_SINGLE 4
`define CFG_Y_DOUBLE 3
`define CFG_Y_SINGLE 2
`define CFG_X_DOUBLE 1
`define CFG_X_SINGLE 0
`define STS_EVENT_ACTIVE 7
`define STS_AXIS_LSB 4
`define STS_DOUBLE 3
`define STS_POL_LSB 0
`define LATENCY_ZERO 8'h00
`define LATENCY_ONE 8'h01
`endif

/* File: inc/tap_gate_if.sv */
// Signals between the register block and the latency gate
interface tap_gate_if;
	logic [7:0] latency;
	logic tick;
	logic first_pulse;
	logic pulse_start;
	logic pulse_end;
	logic abort_en;
	logic ignore_start;
	logic dp_suspend;
	modport regs (output latency, tick, first_pulse, pulse_start, pulse_end, abort_en,
		input ignore_start, dp_suspend);
	modport gate (input latency, tick, first_pulse, pulse_start, pulse_end, abort_en,
		output ignore_start, dp_suspend);
endinterface

/* File: inc/tap_pkg.sv */
// Types shared by the tap register block and its latency gate
package tap_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [2:0] axes_t;
	typedef struct packed {
		byte_t config_r;
		logic event_active_r;
		axes_t axis_r;
		logic double_r;
		axes_t pol_r;
		byte_t rdata_r;
	} regs_s;
	typedef struct packed {
		byte_t count_r;
		logic window_r;
		logic start_seen_r;
		logic suspend_r;
	} gate_s;
endpackage

/* File: rtl/tap_event_config_status.sv */
// Tap event configuration and status register pair
// Function
// R1: With abort clear, double-pulse detection goes on despite a new pulse start in the latency window.
// R2: With abort set, a pulse starting and ending inside the latency window suspends double-pulse detection.
// R3: With latch enable set, the event flag holds until the host reads the status register, which clears it.
// R4: Double-pulse flag enables sit at config bits 5, 3 and 1 for Z, Y and X.
// R5: Single-pulse flag enables sit at config bits 4, 2 and 0 for Z, Y and X.
// R6: Status bit 7 is set when an enabled pulse event has raised the event flag, else zero.
// R7: Status bits 6, 5 and 4 flag an event on Z, Y and X.
// R8: Status bit 3 tells a double pulse (1) from a single pulse (0).
// R9: Status bits 2, 1 and 0 give the pulse polarity of Z, Y and X, 1 for negative.
// R10: The status register at 0x22 is read-only and resets to zero.
// R11: The config register at 0x21 is read/write and resets to zero, leaving detection off.
// R12: After a first pulse, new pulse starts are ignored for the programmed latency.
// R13: With latch enable clear, flags and polarity follow later events.
// R14: The host reads the status register after an event to capture and acknowledge it.
`include "tap_consts.svh"
module tap_event_config_status (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	output tap_pkg::byte_t o_reg_rdata,
	input wire logic [7:0] i_latency,
	input wire logic i_sample_tick,
	input wire logic i_first_pulse,
	input wire logic i_pulse_start,
	input wire logic i_pulse_end,
	input wire tap_pkg::axes_t i_single_pulse,
	input wire tap_pkg::axes_t i_double_pulse,
	input wire tap_pkg::axes_t i_pulse_neg,
	output tap_pkg::byte_t o_tap_config,
	output logic o_tap_event_active,
	output logic o_ignore_start,
	output logic o_dp_suspend
);
	import tap_pkg::*;
	regs_s s_r;
	regs_s s_nxt;
	tap_gate_if gif();
	axes_t single_en;
	axes_t double_en;
	axes_t single_hit;
	axes_t double_hit;
	axes_t hit;
	logic any_hit;
	logic status_rd;
	logic freeze;

	tap_latency_gate u_gate (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.g(gif)
	);

	assign gif.latency = i_latency;
	assign gif.tick = i_sample_tick;
	assign gif.first_pulse = i_first_pulse;
	assign gif.pulse_start = i_pulse_start;
	assign gif.pulse_end = i_pulse_end;
	assign gif.abort_en = s_r.config_r[`CFG_DP_ABORT]; // [R1] [R2]

	always_comb begin
		single_en = {s_r.config_r[`CFG_Z_SINGLE], s_r.config_r[`CFG_Y_SINGLE],
			s_r.config_r[`CFG_X_SINGLE]}; // [R5]
		double_en = {s_r.config_r[`CFG_Z_DOUBLE], s_r.config_r[`CFG_Y_DOUBLE],
			s_r.config_r[`CFG_X_DOUBLE]}; // [R4]
		single_hit = i_single_pulse & single_en; // [R5]
		// Suspended double pulses are dropped, not deferred
		double_hit = i_double_pulse & double_en & {3{~gif.dp_suspend}}; // [R4] [R2]
		hit = single_hit | double_hit;
		any_hit = |hit;
		status_rd = i_reg_rd && (i_reg_addr == `TAP_STATUS_ADDR);
		freeze = s_r.config_r[`CFG_LATCH_EN] && s_r.event_active_r;
	end

	always_comb begin
		s_nxt = s_r;
		if (i_reg_wr && (i_reg_addr == `TAP_CONFIG_ADDR)) begin
			s_nxt.config_r = i_reg_wdata; // [R11]
		end
		// Writes to the status offset are ignored
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				`TAP_CONFIG_ADDR: s_nxt.rdata_r = s_r.config_r; // [R11]
				`TAP_STATUS_ADDR: begin
					s_nxt.rdata_r[`STS_EVENT_ACTIVE] = s_r.event_active_r; // [R6]
					s_nxt.rdata_r[`STS_AXIS_LSB +: 3] = s_r.axis_r; // [R7]
					s_nxt.rdata_r[`STS_DOUBLE] = s_r.double_r; // [R8]
					s_nxt.rdata_r[`STS_POL_LSB +: 3] = s_r.pol_r; // [R9]
				end
				default: s_nxt.rdata_r = '0;
			endcase
		end
		if (status_rd) begin
			// Read clears; a same-cycle event below wins
			s_nxt.event_active_r = 1'b0; // [R3] [R14]
			s_nxt.axis_r = '0;
			s_nxt.double_r = 1'b0;
			s_nxt.pol_r = '0;
		end
		if (any_hit && (!freeze || status_rd)) begin
			s_nxt.event_active_r = 1'b1; // [R6] [R3]
			if (freeze || !s_r.event_active_r || status_rd) begin
				// Fresh capture of the triggering event
				s_nxt.axis_r = hit; // [R7]
				s_nxt.pol_r = i_pulse_neg & hit; // [R9]
			end else begin
				// Later events update flags and polarity
				s_nxt.axis_r = s_r.axis_r | hit; // [R13]
				s_nxt.pol_r = (s_r.pol_r & ~hit) | (i_pulse_neg & hit); // [R13]
			end
			s_nxt.double_r = |double_hit; // [R8] [R13]
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			s_r.config_r <= `TAP_CONFIG_RESET; // [R11]
			s_r.event_active_r <= 1'b0; // [R10]
			s_r.axis_r <= '0;
			s_r.double_r <= 1'b0;
			s_r.pol_r <= '0;
			s_r.rdata_r <= `TAP_STATUS_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_reg_rdata = s_r.rdata_r;
	assign o_tap_config = s_r.config_r;
	assign o_tap_event_active = s_r.event_active_r; // [R6]
	assign o_ignore_start = gif.ignore_start; // [R12]
	assign o_dp_suspend = gif.dp_suspend;
endmodule

/* File: rtl/tap_latency_gate.sv */
// Latency window timer and double-pulse abort logic
`include "tap_consts.svh"
module tap_latency_gate (
	input wire logic i_clock,
	input wire logic i_rstn,
	tap_gate_if.gate g
);
	import tap_pkg::*;
	gate_s s_r;
	gate_s s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (g.first_pulse) begin
			// Window restarts on each first pulse
			s_nxt.count_r = g.latency; // [R12]
			s_nxt.window_r = (g.latency != `LATENCY_ZERO); // [R12]
			s_nxt.start_seen_r = 1'b0;
			s_nxt.suspend_r = 1'b0;
		end else if (s_r.window_r) begin
			if (g.abort_en && g.pulse_start) begin
				s_nxt.start_seen_r = 1'b1; // [R2]
			end
			if (g.abort_en && g.pulse_end && (s_r.start_seen_r || g.pulse_start)) begin
				s_nxt.suspend_r = 1'b1; // [R2]
			end
			if (g.tick) begin
				s_nxt.count_r = s_r.count_r - `LATENCY_ONE;
				if (s_r.count_r == `LATENCY_ONE) begin
					// Suspension holds for the rest of the window: it ends with the window
					s_nxt.window_r = 1'b0;
					s_nxt.start_seen_r = 1'b0;
					s_nxt.suspend_r = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign g.ignore_start = s_r.window_r; // [R12]
	// Abort clear means no suspension ever
	assign g.dp_suspend = s_r.suspend_r && g.abort_en; // [R1] [R2]
endmodule

/* File: test/tap_event_config_status_assertions.sv */
// Port assertions for the tap register pair
module tap_chk (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	input wire tap_pkg::byte_t o_reg_rdata,
	input wire logic [7:0] i_latency,
	input wire logic i_first_pulse,
	input wire tap_pkg::axes_t i_single_pulse,
	input wire tap_pkg::axes_t i_double_pulse,
	input wire tap_pkg::byte_t o_tap_config,
	input wire logic o_tap_event_active,
	input wire logic o_ignore_start,
	input wire logic o_dp_suspend
);
	logic [2:0] s_en, d_en;
	assign s_en = {o_tap_config[4], o_tap_config[2], o_tap_config[0]};
	assign d_en = {o_tap_config[5], o_tap_config[3], o_tap_config[1]};
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	cfg_read_a: assert property (i_reg_rd && i_reg_addr == 8'h21 |=>
		o_reg_rdata == $past(o_tap_config)) else $error("config readback wrong");
	cfg_write_a: assert property (i_reg_wr && i_reg_addr == 8'h21 |=>
		o_tap_config == $past(i_reg_wdata)) else $error("config write lost");
	cfg_hold_a: assert property (!(i_reg_wr && i_reg_addr == 8'h21) |=>
		$stable(o_tap_config)) else $error("config changed without write");
	single_flag_a: assert property (|(i_single_pulse & s_en) |=>
		o_tap_event_active) else $error("single pulse not flagged");
	double_flag_a: assert property (|(i_double_pulse & d_en) && !o_dp_suspend |=>
		o_tap_event_active) else $error("double pulse not flagged");
	flag_cause_a: assert property ($rose(o_tap_event_active) |->
		$past(|(i_single_pulse | i_double_pulse))) else $error("flag without event");
	flag_hold_a: assert property (o_tap_event_active && !i_reg_rd |=>
		o_tap_event_active) else $error("flag dropped without read");
	window_open_a: assert property (i_first_pulse && i_latency != 8'h00 |=>
		o_ignore_start) else $error("latency window not opened");
	no_abort_a: assert property (!$past(o_tap_config[7]) && !o_tap_config[7] |->
		!o_dp_suspend) else $error("suspend with abort clear");
endmodule
bind tap_event_config_status tap_chk i_chk (.*);

/* File: test/tap_event_config_status_tb.sv */
// Testbench for the tap register pair
module tap_event_config_status_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clock = 0, i_rstn = 0, rd, wr, fp = 0, ps = 0, pe = 0, ea, ign, sus, tick = 0;
	logic [7:0] ad, wd, rdat, v, cfg, lat = 8'h02;
	tap_pkg::axes_t sp = 3'h0, dp = 3'h0, ng = 3'h0;
	int err_total = 0, samples_checked = 0, cyc = 0;
	always #5 i_clock = ~i_clock;
	tap_host i_host (.i_clock(i_clock), .o_addr(ad), .o_wr(wr), .o_wdata(wd), .o_rd(rd),
		.i_rdata(rdat));
	tap_event_config_status i_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_reg_addr(ad),
		.i_reg_wr(wr), .i_reg_wdata(wd), .i_reg_rd(rd), .o_reg_rdata(rdat),
		.i_latency(lat), .i_sample_tick(tick), .i_first_pulse(fp), .i_pulse_start(ps),
		.i_pulse_end(pe), .i_single_pulse(sp), .i_double_pulse(dp), .i_pulse_neg(ng),
		.o_tap_config(cfg), .o_tap_event_active(ea), .o_ignore_start(ign), .o_dp_suspend(sus));
	task report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] e);
		i_host.rd(a, v);
		chk(v, e);
	endtask
	task ev(input tap_pkg::axes_t s, input tap_pkg::axes_t d, input tap_pkg::axes_t n);
		@(posedge i_clock);
		{sp, dp, ng} <= {s, d, n};
		@(posedge i_clock);
		{sp, dp} <= 6'h00;
	endtask
	task t_regs;
		rdc(8'h21, 8'h00);
		i_host.wr(8'h22, 8'hff);
		rdc(8'h22, 8'h00);
		i_host.wr(8'h21, 8'h5a);
		rdc(8'h21, 8'h5a);
		chk(cfg, 8'h5a);
	endtask
	task t_axes;
		i_host.wr(8'h21, 8'h15);
		for (int i = 0; i < 3; i++) begin
			ev(3'h1 << i, 3'h0, 3'h1 << i);
			rdc(8'h22, 8'h80 | (8'h10 << i) | (8'h01 << i));
		end
		ev(3'h0, 3'h7, 3'h0);
		rdc(8'h22, 8'h00);
		i_host.wr(8'h21, 8'h2a);
		ev(3'h7, 3'h4, 3'h0);
		rdc(8'h22, 8'hc8);
	endtask
	task t_latch;
		i_host.wr(8'h21, 8'h55);
		ev(3'h1, 3'h0, 3'h1);
		ev(3'h2, 3'h0, 3'h0);
		rdc(8'h22, 8'h91);
		rdc(8'h22, 8'h00);
		i_host.wr(8'h21, 8'h15);
		ev(3'h1, 3'h0, 3'h0);
		ev(3'h2, 3'h0, 3'h0);
		rdc(8'h22, 8'hb0);
	endtask
	// Start and end inside a two-tick window; ticks held off so it stays open
	task t_gate(input logic [7:0] c, input logic s);
		i_host.wr(8'h21, c);
		@(posedge i_clock);
		fp <= 1'b1;
		@(posedge i_clock);
		{fp, ps} <= 2'b01;
		@(posedge i_clock);
		{ps, pe} <= 2'b01;
		@(posedge i_clock);
		pe <= 1'b0;
		@(posedge i_clock);
		#1 chk({6'h00, ign, sus}, {6'h00, 1'b1, s});
		ev(3'h0, 3'h4, 3'h0);
		rdc(8'h22, s ? 8'h00 : 8'hc8);
	endtask
	// Window of two ticks closes on the second; zero latency never opens it
	task t_close;
		@(posedge i_clock);
		fp <= 1'b1;
		@(posedge i_clock);
		{fp, tick} <= 2'b01;
		@(posedge i_clock);
		tick <= 1'b0;
		@(posedge i_clock);
		tick <= 1'b1;
		#1 chk({7'h00, ign}, 8'h01);
		@(posedge i_clock);
		tick <= 1'b0;
		#1 chk({7'h00, ign}, 8'h00);
		@(posedge i_clock);
		{lat, fp} <= {8'h00, 1'b1};
		@(posedge i_clock);
		fp <= 1'b0;
		#1 chk({7'h00, ign}, 8'h00);
		@(posedge i_clock);
		lat <= 8'h02;
	endtask
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			report_and_stop;
		end
	end
	initial begin
		repeat (16) @(posedge i_clock);
		i_rstn <= 1'b1;
		t_regs;
		t_axes;
		t_latch;
		t_gate(8'ha0, 1'b1);
		t_gate(8'h20, 1'b0);
		t_close;
		report_and_stop;
	end
endmodule

/* File: test/tap_host.sv */
// Host model driving the register strobe port
module tap_host (
	input wire logic i_clock,
	output logic [7:0] o_addr,
	output logic o_wr,
	output logic [7:0] o_wdata,
	output logic o_rd,
	input wire logic [7:0] i_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {o_addr, o_wr, o_wdata, o_rd} = 18'h0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		{o_addr, o_wdata, o_wr} <= {a, d, 1'b1};
		@(posedge i_clock);
		{o_addr, o_wr} <= {~a, 1'b0};
	endtask
	// Reads status after events, capturing before clear
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clock);
		{o_addr, o_rd} <= {a, 1'b1};
		@(posedge i_clock);
		{o_addr, o_rd} <= {~a, 1'b0};
		#1 d = i_rdata;
	endtask
endmodule
